// File: hdl/afp_top.sv
// Summary of operation
// - Average overcurrent ends pulse, no shutdown
// - Severe peak shuts that channel in window
// - Overcurrent sets fault pin and channel flag
// - Peak limit only, resumes when cleared
// - Dc offset held long enough triggers
// - Separate positive and negative dc thresholds
// - Dc shutdown off after reset, bit enables
// - Enabled dc trigger shuts only that channel
// - Clip asserted while any channel full duty
// - All channel clips share one pin
// - Setting selects clip, warn, both, tweeter
// - Reset selects warning report on pin
// - Warning with hysteresis drives shared pin
// - Three warning thresholds at register 0x04
// - Temperature shutdown: all Hi-Z, fault, bus alive
// - Shutdown clears at reset level, then restart
// - Undervoltage sets fault and supply flag
// - Power-on reset floats bus, reinit needed
// - Overvoltage sets fault and status flag
// - Load dump shuts device, controller restarts
// - Per-channel gain among four values
// - Current limit selects two load levels
// - Faults go straight to Hi-Z
// - Tweeter mode drives pin low during detection
`timescale 1ns/10ps
`default_nettype none
module afp_top #(
    parameter int NCH    = afp_pkg::NUM_CH,
    parameter int OC_CYC = afp_pkg::OVERCURRENT_SHUTDOWN_CYC
) (
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_reset,
    // AHB-Lite slave
    input  wire logic                   i_hsel,
    input  wire logic [7:0]             i_haddr,
    input  wire logic [1:0]             i_htrans,
    input  wire logic                   i_hwrite,
    input  wire logic [2:0]             i_hsize,
    input  wire logic                   i_hready,
    input  wire logic [31:0]            i_hwdata,
    output logic      [31:0]            o_hrdata,
    output logic                        o_hreadyout,
    output logic                        o_hresp,
    // Comparators
    input  wire afp_pkg::afp_chcmp_s [3:0] i_ch_cmp,
    input  wire afp_pkg::afp_glbcmp_s   i_glb_cmp,
    // Outputs to power stage and pins
    output logic      [3:0]             o_ch_hiz,
    output logic      [3:0]             o_pulse_end,
    output logic      [7:0]             o_gain,
    output logic                        o_ilim_sel,
    output logic                        o_fault_n,
    output logic                        o_fault_oe_n,
    output logic                        o_clip_warn_out_n,
    output logic                        o_clip_warn_oe_n
);
    afp_pkg::afp_chcmp_s [3:0] ch_s;
    afp_pkg::afp_glbcmp_s      glb_s;

    // Every comparator enters through its own two-flop stage.
    afp_sync #(.W($bits(afp_pkg::afp_chcmp_s) * 4)) u_sync_ch (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async (i_ch_cmp),
        .o_sync  (ch_s)
    );
    afp_sync #(.W($bits(afp_pkg::afp_glbcmp_s))) u_sync_glb (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async (i_glb_cmp),
        .o_sync  (glb_s)
    );

    // Registers.
    logic [31:0] ctrl_r;
    logic [7:0]  gain_r;
    logic [31:0] dccfg_r;
    logic [3:0]  oc_flag_r;
    logic [3:0]  dc_flag_r;
    logic [4:0]  sup_flag_r;
    logic        tsd_flag_r;
    logic        tsd_hold_r;
    logic        clr_r;
    logic        warn_r;

    // Bus address phase capture.
    logic        wr_pend_r;
    logic [7:0]  addr_r;
    wire         xfer    = i_hsel & i_hready & i_htrans[1];
    wire  [7:0]  rd_a    = {i_haddr[7:2], 2'b00};
    wire         wr_ctrl = wr_pend_r & (addr_r == afp_pkg::ADDR_CTRL);
    wire         wr_gain = wr_pend_r & (addr_r == afp_pkg::ADDR_GAIN);
    wire         wr_dc   = wr_pend_r & (addr_r == afp_pkg::ADDR_DCCFG);
    wire         wr_cmd  = wr_pend_r & (addr_r == afp_pkg::ADDR_CMD);
    wire [3:0]   cmd_rst = wr_cmd ? i_hwdata[afp_pkg::CMD_RESTART_LSB +: 4] : 4'h0;
    wire         cmd_clr = wr_cmd & i_hwdata[afp_pkg::CMD_CLRFLT_BIT];
    wire         cmd_tsd = wr_cmd & i_hwdata[afp_pkg::CMD_TSDRST_BIT];

    // Channel protection.
    logic [3:0] oc_sd;
    logic [3:0] dc_trig;
    logic [3:0] pend;
    wire        dc_sd_en = ctrl_r[afp_pkg::CTRL_DCSD_BIT];

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_ch
            afp_chan #(.OC_CYC(OC_CYC), .DCW(16)) u_chan (
                .i_clk       (i_clk),
                .i_reset     (i_reset),
                .i_cmp       (ch_s[g]),
                .i_dc_sd_en  (dc_sd_en),
                .i_dc_time   (dccfg_r[15:0]),
                .i_restart   (cmd_rst[g]),
                .o_oc_sd     (oc_sd[g]),
                .o_dc_trig   (dc_trig[g]),
                .o_pulse_end (pend[g])
            );
        end
    endgenerate

    // Load dump and undervoltage stop every channel; temperature shutdown too.
    wire       glb_hiz   = tsd_hold_r | glb_s.ldump | glb_s.uv_power_stage_supply | glb_s.uv_analog_supply
                           | glb_s.uv_cp | glb_s.ov;
    wire [3:0] dc_hiz    = dc_trig & {4{dc_sd_en}};
    wire [3:0] hiz_nxt   = oc_sd | dc_hiz | {4{glb_hiz}};
    wire [4:0] sup_evt   = {glb_s.ldump, glb_s.ov, glb_s.uv_cp, glb_s.uv_analog_supply,
                            glb_s.uv_power_stage_supply};
    wire       any_act   = |oc_sd | |dc_hiz | glb_hiz;
    wire       any_lat   = |oc_flag_r | |dc_flag_r | |sup_flag_r | tsd_flag_r;
    wire       fault_nxt = any_act | any_lat;
    wire       clip_any  = |{ch_s[3].full_duty, ch_s[2].full_duty,
                             ch_s[1].full_duty, ch_s[0].full_duty};
    wire       tw_any    = |{ch_s[3].tweeter, ch_s[2].tweeter,
                             ch_s[1].tweeter, ch_s[0].tweeter};
    wire [1:0] csel      = ctrl_r[afp_pkg::CTRL_CLIPSEL_LSB +: 2];
    wire       warn_nxt  = glb_s.warn1 ? 1'b1 : (~glb_s.warn1 & 1'b0);
    logic      cw_act;

    always_comb
    begin
        case (afp_pkg::afp_clipsel_e'(csel))
            afp_pkg::AFP_CLIP_ONLY: cw_act = clip_any;
            afp_pkg::AFP_WARN_ONLY: cw_act = warn_r;
            afp_pkg::AFP_CLIP_WARN: cw_act = clip_any | warn_r;
            afp_pkg::AFP_TWEETER:   cw_act = tw_any;
            default:                cw_act = 1'b0;
        endcase
    end

    // Read mux.
    wire [31:0] temp_rd  = {24'h000000, glb_s.warn3, glb_s.warn2, glb_s.warn1,
                            5'h00};
    wire [31:0] fault_rd = {18'h00000, tsd_flag_r, sup_flag_r, dc_flag_r,
                            oc_flag_r};
    // Read data is loaded at the address edge so that it stands in the data phase.
    wire [31:0] rd_nxt   =
        (rd_a == afp_pkg::ADDR_CTRL)  ? ctrl_r :
        (rd_a == afp_pkg::ADDR_GAIN)  ? {24'h000000, gain_r} :
        (rd_a == afp_pkg::ADDR_DCCFG) ? dccfg_r :
        (rd_a == afp_pkg::ADDR_TEMP)  ? temp_rd :
        (rd_a == afp_pkg::ADDR_FAULT) ? fault_rd : 32'h00000000;

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            wr_pend_r <= 1'b0;
            addr_r    <= 8'h00;
            o_hrdata  <= 32'h00000000;
        end
        else
        begin
            wr_pend_r <= xfer & i_hwrite;
            if (xfer)
                addr_r <= rd_a;
            if (xfer & ~i_hwrite)
                o_hrdata <= rd_nxt;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            ctrl_r   <= afp_pkg::CTRL_RST;
            gain_r   <= afp_pkg::GAIN_RST[7:0];
            dccfg_r  <= afp_pkg::DCCFG_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_r <= {28'h0000000, i_hwdata[3:0]};
            if (wr_gain)
                gain_r <= i_hwdata[7:0];
            if (wr_dc)
                dccfg_r <= i_hwdata;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            oc_flag_r  <= 4'h0;
            dc_flag_r  <= 4'h0;
            sup_flag_r <= 5'h00;
            tsd_flag_r <= 1'b0;
            tsd_hold_r <= 1'b0;
            clr_r      <= 1'b0;
            warn_r     <= 1'b0;
        end
        else
        begin
            clr_r      <= cmd_clr;
            // Set wins over clear; the clear lags one cycle so a restart in the
            // same command has dropped the channel shutdown first.
            oc_flag_r  <= oc_sd | (clr_r ? 4'h0 : oc_flag_r);
            dc_flag_r  <= dc_trig | (clr_r ? 4'h0 : dc_flag_r);
            sup_flag_r <= sup_evt | (clr_r ? 5'h00 : sup_flag_r);
            tsd_flag_r <= glb_s.tsd | (clr_r ? 1'b0 : tsd_flag_r);
            // Hi-Z holds after cooling to the reset level until software restarts.
            if (glb_s.tsd)
                tsd_hold_r <= 1'b1;
            else if (cmd_tsd)
                tsd_hold_r <= 1'b0;
            // Warn comparator includes the hysteresis band itself.
            warn_r     <= warn_nxt;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_ch_hiz          <= 4'hF;
            o_pulse_end       <= 4'h0;
            o_gain            <= 8'h00;
            o_ilim_sel        <= 1'b0;
            o_fault_n         <= 1'b1;
            o_fault_oe_n      <= 1'b1;
            o_clip_warn_out_n <= 1'b1;
            o_clip_warn_oe_n  <= 1'b1;
            o_hreadyout       <= 1'b1;
            o_hresp           <= 1'b0;
        end
        else
        begin
            o_ch_hiz          <= hiz_nxt;
            o_pulse_end       <= pend;
            o_gain            <= gain_r;
            o_ilim_sel        <= ctrl_r[afp_pkg::CTRL_ILIM_BIT];
            o_fault_n         <= ~fault_nxt;
            o_fault_oe_n      <= ~fault_nxt;
            o_clip_warn_out_n <= ~cw_act;
            o_clip_warn_oe_n  <= ~cw_act;
            o_hreadyout       <= 1'b1;
            o_hresp           <= 1'b0;
        end
    end
endmodule // afp_top
`default_nettype wire

// File: hdl/afp_pkg.sv
package afp_pkg;

    localparam int NUM_CH = 4;

    // Clock rate and timing.
    localparam int CLK_HZ        = 10000000;
    localparam int OVERCURRENT_SHUTDOWN_MIN_US   = 200;
    localparam int OVERCURRENT_SHUTDOWN_MAX_US   = 390;
    // Shutdown lands inside the window; the target sits between both ends.
    localparam int OVERCURRENT_SHUTDOWN_MIN_CYC  = (OVERCURRENT_SHUTDOWN_MIN_US * (CLK_HZ / 1000000));
    localparam int OVERCURRENT_SHUTDOWN_MAX_CYC  = (OVERCURRENT_SHUTDOWN_MAX_US * (CLK_HZ / 1000000));
    localparam int OVERCURRENT_SHUTDOWN_CYC      = (OVERCURRENT_SHUTDOWN_MIN_CYC + OVERCURRENT_SHUTDOWN_MAX_CYC) / 2;
    localparam int DC_TIME_DEF   = 1000;

    // Register byte addresses.
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_GAIN     = 8'h08;
    localparam logic [7:0] ADDR_DCCFG    = 8'h0C;
    localparam logic [7:0] ADDR_TEMP     = 8'h04;
    localparam logic [7:0] ADDR_FAULT    = 8'h10;
    localparam logic [7:0] ADDR_CMD      = 8'h14;

    // Field positions.
    localparam int CTRL_CLIPSEL_LSB = 0;
    localparam int CTRL_DCSD_BIT    = 2;
    localparam int CTRL_ILIM_BIT    = 3;
    localparam int TEMP_W1_BIT      = 5;
    localparam int TEMP_W2_BIT      = 6;
    localparam int TEMP_W3_BIT      = 7;
    localparam int CMD_RESTART_LSB  = 0;
    localparam int CMD_CLRFLT_BIT   = 4;
    localparam int CMD_TSDRST_BIT   = 5;
    localparam int FLT_OC_LSB       = 0;
    localparam int FLT_DC_LSB       = 4;
    localparam int FLT_UVP_BIT      = 8;
    localparam int FLT_UVA_BIT      = 9;
    localparam int FLT_UVC_BIT      = 10;
    localparam int FLT_OV_BIT       = 11;
    localparam int FLT_LD_BIT       = 12;
    localparam int FLT_TSD_BIT      = 13;

    // Reset values.
    localparam logic [31:0] CTRL_RST  = 32'h00000001;
    localparam logic [31:0] GAIN_RST  = 32'h00000000;
    localparam logic [31:0] DCCFG_RST = 32'h00000000;

    typedef enum logic [1:0] {
        AFP_CLIP_ONLY = 2'h0,
        AFP_WARN_ONLY = 2'h1,
        AFP_CLIP_WARN = 2'h2,
        AFP_TWEETER   = 2'h3
    } afp_clipsel_e;

    typedef enum logic [1:0] {
        AFP_GAIN_12DB = 2'h0,
        AFP_GAIN_20DB = 2'h1,
        AFP_GAIN_26DB = 2'h2,
        AFP_GAIN_32DB = 2'h3
    } afp_gain_e;

    // Per-channel comparator bundle.
    typedef struct packed {
        logic avg_over;
        logic peak_over;
        logic peak_severe;
        logic dc_pos;
        logic dc_neg;
        logic full_duty;
        logic tweeter;
    } afp_chcmp_s;

    // Global comparator bundle.
    typedef struct packed {
        logic warn1;
        logic warn2;
        logic warn3;
        logic tsd;
        logic uv_power_stage_supply;
        logic uv_analog_supply;
        logic uv_cp;
        logic ov;
        logic ldump;
    } afp_glbcmp_s;

endpackage : afp_pkg

// File: hdl/afp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module afp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_reset,
    // Data
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_r;

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            meta_r <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule // afp_sync
`default_nettype wire

// File: hdl/afp_chan.sv
`timescale 1ns/10ps
`default_nettype none
module afp_chan #(
    parameter int OC_CYC = afp_pkg::OVERCURRENT_SHUTDOWN_CYC,
    parameter int DCW    = 16
) (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    // Synchronised comparators
    input  wire afp_pkg::afp_chcmp_s i_cmp,
    // Control
    input  wire logic              i_dc_sd_en,
    input  wire logic [DCW-1:0]    i_dc_time,
    input  wire logic              i_restart,
    // Status
    output logic                   o_oc_sd,
    output logic                   o_dc_trig,
    output logic                   o_pulse_end
);
    logic [15:0]    oc_cnt_r;
    logic [DCW-1:0] dc_cnt_r;
    wire            dc_beyond = i_cmp.dc_pos | i_cmp.dc_neg;
    wire            oc_done   = (oc_cnt_r >= 16'(OC_CYC - 1));
    wire            dc_done   = (dc_cnt_r >= i_dc_time) & dc_beyond;

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            oc_cnt_r    <= '0;
            dc_cnt_r    <= '0;
            o_oc_sd     <= 1'b0;
            o_dc_trig   <= 1'b0;
            o_pulse_end <= 1'b0;
        end
        else
        begin
            // Terminates the pulse only; no shutdown.
            o_pulse_end <= (i_cmp.avg_over | i_cmp.peak_over) & ~o_oc_sd;
            // A severe peak must persist; shorter bursts only limit current.
            if (i_cmp.peak_severe & ~o_oc_sd)
                oc_cnt_r <= oc_done ? oc_cnt_r : oc_cnt_r + 16'h0001;
            else
                oc_cnt_r <= '0;
            if (i_cmp.peak_severe & oc_done)
                o_oc_sd <= 1'b1;
            else if (i_restart)
                o_oc_sd <= 1'b0;
            if (dc_beyond & ~o_dc_trig)
                dc_cnt_r <= dc_done ? dc_cnt_r : dc_cnt_r + 1'b1;
            else
                dc_cnt_r <= '0;
            if (dc_done)
                o_dc_trig <= 1'b1;
            else if (i_restart | ~i_dc_sd_en)
                o_dc_trig <= 1'b0;
        end
    end
endmodule // afp_chan
`default_nettype wire

// File: tb/afp_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module afp_top_sva #(
    parameter int OC_CYC = 8
) (
    // Clock and reset
    input wire logic                      i_clk,
    input wire logic                      i_reset,
    // Bus and comparators
    input wire logic                      i_hsel,
    input wire logic [7:0]                i_haddr,
    input wire logic [1:0]                i_htrans,
    input wire logic                      i_hwrite,
    input wire logic                      i_hready,
    input wire logic [31:0]               i_hwdata,
    input wire afp_pkg::afp_chcmp_s [3:0] i_ch_cmp,
    input wire afp_pkg::afp_glbcmp_s      i_glb_cmp,
    // Design outputs
    input wire logic [3:0]                o_ch_hiz,
    input wire logic [3:0]                o_pulse_end,
    input wire logic [7:0]                o_gain,
    input wire logic                      o_fault_n,
    input wire logic                      o_clip_warn_out_n
);
    logic       wr_ph_r;
    logic [7:0] wr_a_r;
    logic       ctl_wr_r;
    logic       g_upd_r;
    logic [7:0] g_val_r;
    logic [7:0] sev_cnt_r;
    wire        take_w = i_hsel & i_hready & i_htrans[1] & i_hwrite;
    wire        sev_w  = i_ch_cmp[0].peak_severe;

    // The warning default only holds until software first touches the control word.
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            wr_ph_r   <= 1'b0;
            wr_a_r    <= 8'h00;
            ctl_wr_r  <= 1'b0;
            g_upd_r   <= 1'b0;
            g_val_r   <= 8'h00;
            sev_cnt_r <= 8'h00;
        end
        else
        begin
            wr_ph_r   <= take_w;
            wr_a_r    <= i_haddr;
            ctl_wr_r  <= ctl_wr_r | (wr_ph_r && wr_a_r == afp_pkg::ADDR_CTRL);
            g_upd_r   <= wr_ph_r && wr_a_r == afp_pkg::ADDR_GAIN;
            g_val_r   <= (wr_ph_r) ? i_hwdata[7:0] : g_val_r;
            sev_cnt_r <= (!sev_w) ? 8'h00 : sev_cnt_r + {7'h00, sev_cnt_r != 8'hFF};
        end
    end

    default clocking dc_cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    pulse_end_a : assert property (i_ch_cmp[1].avg_over [*5] |-> o_pulse_end[1])
        else $error("pulse end missing after average overcurrent");
    oc_shut_a : assert property (sev_cnt_r == OC_CYC + 8 |-> o_ch_hiz[0])
        else $error("channel not shut down after severe overcurrent");
    hiz_fault_a : assert property ($rose(|o_ch_hiz) |-> ##[0:2] !o_fault_n)
        else $error("channel went Hi-Z without fault pin");
    warn_default_a : assert property ((!ctl_wr_r && i_glb_cmp.warn1) [*6] |->
        !o_clip_warn_out_n)
        else $error("warning not shown on shared pin after reset");
    tsd_all_a : assert property (i_glb_cmp.tsd [*6] |-> &o_ch_hiz && !o_fault_n)
        else $error("overtemperature shutdown incomplete");
    uv_fault_a : assert property (i_glb_cmp.uv_power_stage_supply [*6] |-> !o_fault_n)
        else $error("undervoltage without fault pin");
    ov_fault_a : assert property (i_glb_cmp.ov [*6] |-> !o_fault_n)
        else $error("overvoltage without fault pin");
    ldump_off_a : assert property (i_glb_cmp.ldump [*6] |-> &o_ch_hiz)
        else $error("load dump did not shut outputs");
    gain_set_a : assert property (g_upd_r |-> ##[0:1] o_gain == g_val_r)
        else $error("gain output does not follow write");
endmodule // afp_top_sva

bind afp_top afp_top_sva #(.OC_CYC(OC_CYC)) u_sva (.i_clk, .i_reset, .i_hsel, .i_haddr,
    .i_htrans, .i_hwrite, .i_hready, .i_hwdata, .i_ch_cmp, .i_glb_cmp, .o_ch_hiz,
    .o_pulse_end, .o_gain, .o_fault_n, .o_clip_warn_out_n);
`default_nettype wire

// File: tb/afp_host.sv
`timescale 1ns/10ps
`default_nettype none
module afp_host (
    // Clock
    input  wire logic        i_clk,
    // Bus master requests
    output logic             o_hsel,
    output logic [7:0]       o_haddr,
    output logic [1:0]       o_htrans,
    output logic             o_hwrite,
    output logic [2:0]       o_hsize,
    output logic [31:0]      o_hwdata,
    // Slave answers
    input  wire logic        i_hready,
    input  wire logic [31:0] i_hrdata
);
    int n_lost;

    initial
    begin
        n_lost   = 0;
        o_hsel   = 1'b1;
        o_haddr  = 8'h00;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hsize  = 3'h2;
        o_hwdata = 32'h0;
    end

    // A stuck slave is counted instead of hanging the run.
    task automatic wait_rdy();
        int k;
        k = 0;
        do
        begin
            @(posedge i_clk);
            k++;
        end
        while (i_hready !== 1'b1 && k < 50);
        if (i_hready !== 1'b1)
            n_lost++;
    endtask

    // Read data stands in the data phase and is taken at its closing edge.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge i_clk);
        o_haddr  <= a;
        o_hwrite <= w;
        o_htrans <= 2'h2;
        wait_rdy();
        o_htrans <= 2'h0;
        o_hwdata <= d;
        wait_rdy();
        q = i_hrdata;
    endtask
endmodule // afp_host
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int GPOS [6] = '{5, 4, 3, 2, 1, 0};
    localparam int FBIT [6] = '{13, 8, 9, 10, 11, 12};
    logic                      i_clk;
    logic                      i_reset;
    afp_pkg::afp_chcmp_s [3:0] ch;
    afp_pkg::afp_glbcmp_s      glb;
    wire logic                 hsel, hwrite, hready, ilim, fault_n, clip_n;
    wire logic [7:0]           haddr, gain;
    wire logic [1:0]           htrans;
    wire logic [2:0]           hsize;
    wire logic [31:0]          hwdata, hrdata;
    wire logic [3:0]           hiz, pend;
    int                        errors;
    int                        n_compared;

    afp_host host (.i_clk(i_clk), .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans),
        .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata), .i_hready(hready),
        .i_hrdata(hrdata));
    afp_top #(.OC_CYC(8)) DUT (.i_clk(i_clk), .i_reset(i_reset), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hready(hready), .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hready),
        .o_hresp(), .i_ch_cmp(ch), .i_glb_cmp(glb), .o_ch_hiz(hiz), .o_pulse_end(pend),
        .o_gain(gain), .o_ilim_sel(ilim), .o_fault_n(fault_n), .o_fault_oe_n(),
        .o_clip_warn_out_n(clip_n), .o_clip_warn_oe_n());

    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        host.xfer(a, 1'b0, 32'h0, q);
        chk(q, e);
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic give_verdict();
        errors += host.n_lost;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        errors = 0;
        n_compared = 0;
        i_reset = 1'b1;
        ch = '0;
        glb = '0;
        hold(6);
        i_reset <= 1'b0;
        rd(afp_pkg::ADDR_CTRL, afp_pkg::CTRL_RST);
        rd(afp_pkg::ADDR_GAIN, afp_pkg::GAIN_RST);
        rd(afp_pkg::ADDR_DCCFG, afp_pkg::DCCFG_RST);
        rd(8'h1C, 32'h0);
        chk(32'(fault_n), 32'h1);
        glb.warn1 <= 1'b1;
        hold(8);
        chk(32'(clip_n), 32'h0);
        glb <= '0;
        wr(afp_pkg::ADDR_CMD, 32'h3F);
        hold(4);
        chk(32'(hiz), 32'h0);
        $display("test reset done");
        wr(afp_pkg::ADDR_GAIN, 32'hE4);
        wr(afp_pkg::ADDR_CTRL, 32'h8);
        hold(2);
        chk(32'(gain), 32'hE4);
        chk(32'(ilim), 32'h1);
        for (int c = 0; c < 4; c++)
        begin
            ch[c].full_duty <= 1'b1;
            hold(8);
            chk(32'(clip_n), 32'h0);
            ch[c].full_duty <= 1'b0;
            hold(8);
            chk(32'(clip_n), 32'h1);
        end
        // Bit m*3+s tells whether source s pulls the pin low in mode m.
        for (int m = 0; m < 4; m++)
        begin
            wr(afp_pkg::ADDR_CTRL, 32'(m));
            for (int s = 0; s < 3; s++)
            begin
                ch[0].full_duty <= (s == 0);
                glb.warn1 <= (s == 1);
                ch[0].tweeter <= (s == 2);
                hold(8);
                chk(32'(clip_n), 32'(!(12'h8D1 >> (m * 3 + s) & 12'h1)));
            end
        end
        ch <= '0;
        glb <= '0;
        $display("test config and clip done");
        ch[1].avg_over <= 1'b1;
        ch[3].peak_over <= 1'b1;
        hold(30);
        chk(32'(pend), 32'hA);
        chk(32'(hiz), 32'h0);
        ch[0].peak_severe <= 1'b1;
        ch[1].avg_over <= 1'b0;
        ch[3].peak_over <= 1'b0;
        hold(5);
        chk(32'(hiz), 32'h0);
        hold(20);
        chk(32'(hiz), 32'h1);
        chk(32'(fault_n), 32'h0);
        rd(afp_pkg::ADDR_FAULT, 32'h1);
        ch[0].peak_severe <= 1'b0;
        hold(20);
        chk(32'(hiz), 32'h1);
        rd(afp_pkg::ADDR_FAULT, 32'h1);
        wr(afp_pkg::ADDR_CMD, 32'h11);
        hold(4);
        chk(32'(hiz), 32'h0);
        chk(32'(fault_n), 32'h1);
        $display("test overcurrent done");
        wr(afp_pkg::ADDR_DCCFG, 32'h4);
        wr(afp_pkg::ADDR_CTRL, 32'h1);
        ch[1].dc_pos <= 1'b1;
        hold(20);
        chk(32'(hiz), 32'h0);
        ch[1].dc_pos <= 1'b0;
        hold(4);
        wr(afp_pkg::ADDR_CMD, 32'h10);
        wr(afp_pkg::ADDR_CTRL, 32'h5);
        ch[3].dc_pos <= 1'b1;
        hold(2);
        ch[3].dc_pos <= 1'b0;
        hold(8);
        chk(32'(hiz), 32'h0);
        ch[2].dc_neg <= 1'b1;
        hold(20);
        chk(32'(hiz), 32'h4);
        chk(32'(fault_n), 32'h0);
        rd(afp_pkg::ADDR_FAULT, 32'h40);
        ch[2].dc_neg <= 1'b0;
        hold(4);
        wr(afp_pkg::ADDR_CMD, 32'h14);
        hold(4);
        chk(32'(hiz), 32'h0);
        $display("test dc offset done");
        glb <= 9'h1C0;
        hold(8);
        rd(afp_pkg::ADDR_TEMP, 32'hE0);
        for (int i = 0; i < 6; i++)
        begin
            glb <= 9'(1 << GPOS[i]);
            hold(10);
            chk(32'(fault_n), 32'h0);
            chk(32'(hiz), 32'hF);
            rd(afp_pkg::ADDR_FAULT, 32'h1 << FBIT[i]);
            wr(afp_pkg::ADDR_CMD, 32'h3F);
            hold(4);
            chk(32'(hiz), 32'hF);
            glb <= '0;
            hold(8);
            wr(afp_pkg::ADDR_CMD, 32'h3F);
            hold(6);
            chk(32'(fault_n), 32'h1);
            chk(32'(hiz), 32'h0);
        end
        $display("test supply and temperature done");
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
